// ---- verilog/apg_defs.vh ----
/*
 Constants of the amplifier power guard: register offsets, field positions,
 reset values and data path sizes.
 Assumes inclusion by its bare name from the design file.
*/
`ifndef APG_DEFS_VH
`define APG_DEFS_VH

// ==========================================================
// Register map (byte addresses)
`define APG_OFS_CTRL     5'h00
`define APG_OFS_STEP     5'h04
`define APG_OFS_WAIT     5'h08
`define APG_OFS_THRESH   5'h0c
`define APG_OFS_STATUS   5'h10
`define APG_OFS_ACCUM    5'h14

// ==========================================================
// Control fields
`define APG_CTRL_EN      0
`define APG_CTRL_SRC     1
`define APG_CTRL_SYNC    2
`define APG_CTRL_LEN_LO  4
`define APG_CTRL_LEN_HI  5
`define APG_LEN_32       2'h0
`define APG_LEN_64       2'h1
`define APG_LEN_128      2'h2
`define APG_DLY_32       5'h04
`define APG_DLY_64       5'h08
`define APG_DLY_128      5'h10

// ==========================================================
// Status fields
`define APG_ST_ACTIVE    0
`define APG_ST_TRIG      1
`define APG_ST_STATE_LO  2
`define APG_ST_STATE_HI  3
`define APG_ST_GAIN_LO   16
`define APG_ST_GAIN_HI   26

// ==========================================================
// Reset values and sizes
`define APG_GAIN_W       11
`define APG_GAIN_FRAC    10
`define APG_GAIN_UNITY   11'h400
`define APG_STEP_RST     10'h001
`define APG_WAIT_RST     16'h0000
`define APG_THRESH_RST   16'hffff
`define APG_NSAMP        16
`define APG_NDET         8

`endif

// ---- verilog/apg_guard.v ----
/*
 Amplifier power guard: moving-sum power detector, threshold trigger and a
 four-state gain ramp applied to sixteen 16-bit samples per clock, with an
 Avalon-MM register slave.
 Assumes samples arrive synchronous to i_core_clk, one word of sixteen per
 clock, sample 0 in the low bits; the bus master holds requests while
 waitrequest is high.
*/
`include "apg_defs.vh"
`default_nettype none

module apg_guard (
	input  wire         i_core_clk,         // 200 MHz core clock
	input  wire         i_nrst,             // Asynchronous reset, active low
	input  wire [255:0] i_data,             // Sixteen signed input samples
	input  wire         i_sync,             // External sync pulse
	output reg  [255:0] o_data,             // Sixteen scaled output samples
	output reg          o_trig,             // Protection trigger
	input  wire [4:0]   i_avs_address,      // Byte address
	input  wire         i_avs_read,         // Read request
	input  wire         i_avs_write,        // Write request
	input  wire [31:0]  i_avs_writedata,    // Write data
	output reg  [31:0]  o_avs_readdata,     // Read data
	output reg          o_avs_waitrequest   // Stall, low for the accepting edge
);

	localparam [1:0] ST_NORMAL = 2'h0;
	localparam [1:0] ST_ATTEN  = 2'h1;
	localparam [1:0] ST_WAIT   = 2'h2;
	localparam [1:0] ST_GAIN   = 2'h3;

	// ==========================================================
	// Register slave
	reg         en_ff;
	reg         src_ff;
	reg  [1:0]  len_ff;
	reg  [9:0]  step_ff;
	reg  [15:0] wait_ff;
	reg  [15:0] thresh_ff;
	reg         active_ff;
	reg         sw_sync_ff;
	reg  [1:0]  state_ff;
	reg  [`APG_GAIN_W-1:0] gain_ff;
	reg  [15:0] acc_ff;
	reg         trig_ff;
	reg  [31:0] nxt_rdata;

	// ==========================================================
	// Address decode
	// Read data are captured on the edge that first sees a read and
	// accepted on the next, so the read mux never drives the bus directly
	// and the data stand when the master samples waitrequest low.
	wire req    = i_avs_read | i_avs_write;
	wire accept = req & ~o_avs_waitrequest;
	wire rd_cap = i_avs_read & o_avs_waitrequest;
	wire wr_acc = accept & i_avs_write;

	wire wr_ctl = wr_acc & (i_avs_address == `APG_OFS_CTRL);
	wire wr_stp = wr_acc & (i_avs_address == `APG_OFS_STEP);
	wire wr_wtc = wr_acc & (i_avs_address == `APG_OFS_WAIT);
	wire wr_thr = wr_acc & (i_avs_address == `APG_OFS_THRESH);
	wire wr_sts = wr_acc & (i_avs_address == `APG_OFS_STATUS);
	wire [1:0] wr_len = i_avs_writedata[`APG_CTRL_LEN_HI:`APG_CTRL_LEN_LO];
	wire len_ok = (wr_len != 2'h3);
	wire len_chg = wr_ctl & len_ok & (wr_len != len_ff);

	// One wait cycle per access; a request is accepted on its second edge.
	always @(posedge i_core_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			o_avs_waitrequest <= 1'b1;
		else
			o_avs_waitrequest <= ~(req & o_avs_waitrequest);
	end

	always @*
	begin
		nxt_rdata = 32'h0000_0000;
		case (i_avs_address)
		`APG_OFS_CTRL:
		begin
			nxt_rdata[`APG_CTRL_EN]  = en_ff;
			nxt_rdata[`APG_CTRL_SRC] = src_ff;
			nxt_rdata[`APG_CTRL_LEN_HI:`APG_CTRL_LEN_LO] = len_ff;
		end
		`APG_OFS_STEP:   nxt_rdata[9:0]  = step_ff;
		`APG_OFS_WAIT:   nxt_rdata[15:0] = wait_ff;
		`APG_OFS_THRESH: nxt_rdata[15:0] = thresh_ff;
		`APG_OFS_STATUS:
		begin
			nxt_rdata[`APG_ST_ACTIVE] = active_ff;
			nxt_rdata[`APG_ST_TRIG]   = trig_ff;
			nxt_rdata[`APG_ST_STATE_HI:`APG_ST_STATE_LO] = state_ff;
			nxt_rdata[`APG_ST_GAIN_HI:`APG_ST_GAIN_LO]   = gain_ff;
		end
		`APG_OFS_ACCUM:  nxt_rdata[15:0] = acc_ff;
		default:         nxt_rdata = 32'h0000_0000;
		endcase
	end

	always @(posedge i_core_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			en_ff          <= 1'b0;
			src_ff         <= 1'b0;
			len_ff         <= `APG_LEN_32;
			step_ff        <= `APG_STEP_RST;
			wait_ff        <= `APG_WAIT_RST;
			thresh_ff      <= `APG_THRESH_RST;
			sw_sync_ff     <= 1'b0;
			o_avs_readdata <= 32'h0000_0000;
		end
		else
		begin
			sw_sync_ff <= 1'b0;
			// Loaded while waitrequest is still high, held until the next read.
			if (rd_cap)
				o_avs_readdata <= nxt_rdata;
			if (wr_ctl)
			begin
				en_ff      <= i_avs_writedata[`APG_CTRL_EN];
				src_ff     <= i_avs_writedata[`APG_CTRL_SRC];
				sw_sync_ff <= i_avs_writedata[`APG_CTRL_SYNC];
				// An unsupported length code is ignored.
				if (len_ok)
					len_ff <= wr_len;
			end
			if (wr_stp)
				step_ff <= i_avs_writedata[9:0];
			if (wr_wtc)
				wait_ff <= i_avs_writedata[15:0];
			if (wr_thr)
				thresh_ff <= i_avs_writedata[15:0];
		end
	end

	// ==========================================================
	// Sync: clears the detector so that its window starts afresh.
	wire sync_evt = src_ff ? sw_sync_ff : i_sync;
	// A length change also restarts the window, since the old delay taps
	// no longer match the new sum length.
	wire det_clr = ~en_ff | sync_evt | len_chg;

	// ==========================================================
	// Detector: absolute upper bytes of samples 0..7, summed
	// Only samples 0..7 are measured; samples 8..15 are scaled but unseen.
	// A byte of -128 gives magnitude 128, which still fits eight bits.
	wire [10:0] psum [0:`APG_NDET];
	assign psum[0] = 11'h000;
	genvar gi;
	generate
		for (gi = 0; gi < `APG_NDET; gi = gi + 1)
		begin : g_det
			wire [7:0] hb  = i_data[gi*16+15:gi*16+8];
			wire [7:0] mag = hb[7] ? (~hb + 8'h01) : hb;
			assign psum[gi+1] = psum[gi] + {3'h0, mag};
		end
	endgenerate

	reg  [10:0] sum_ff;
	reg  [10:0] dly_ff [0:15];
	reg  [3:0]  ptr_ff;
	wire [4:0]  dly_len = (len_ff == `APG_LEN_32) ? `APG_DLY_32 :
		(len_ff == `APG_LEN_64) ? `APG_DLY_64 : `APG_DLY_128;
	wire [3:0]  ptr_last = dly_len[3:0] - 4'h1;
	wire [10:0] old_sum = dly_ff[ptr_ff];
	// At most sixteen slots of 8 x 128 each, so the moving sum never wraps.
	wire [15:0] nxt_acc = acc_ff + {5'h00, sum_ff} - {5'h00, old_sum};

	// The ring slot at ptr was written one full window ago, so it holds
	// the sum that now leaves the window.
	always @(posedge i_core_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			sum_ff  <= 11'h000;
			ptr_ff  <= 4'h0;
			acc_ff  <= 16'h0000;
			trig_ff <= 1'b0;
		end
		else if (det_clr)
		begin
			sum_ff  <= 11'h000;
			ptr_ff  <= 4'h0;
			acc_ff  <= 16'h0000;
			trig_ff <= 1'b0;
		end
		else
		begin
			sum_ff  <= psum[`APG_NDET];
			ptr_ff  <= (ptr_ff == ptr_last) ? 4'h0 : ptr_ff + 4'h1;
			acc_ff  <= nxt_acc;
			// Strictly greater: a sum equal to the threshold does not trip.
			trig_ff <= (acc_ff > thresh_ff);
		end
	end

	// One slot per clock of the longest window; shorter windows wrap early.
	generate
		for (gi = 0; gi < 16; gi = gi + 1)
		begin : g_dly
			always @(posedge i_core_clk or negedge i_nrst)
			begin
				if (!i_nrst)
					dly_ff[gi] <= 11'h000;
				else if (det_clr)
					dly_ff[gi] <= 11'h000;
				else if ({28'h000_0000, ptr_ff} == gi)
					dly_ff[gi] <= sum_ff;
			end
		end
	endgenerate

	// ==========================================================
	// Gain state machine
	reg  [1:0]  nxt_state;
	reg  [`APG_GAIN_W-1:0] nxt_gain;
	reg  [15:0] cnt_ff;
	reg  [15:0] nxt_cnt;
	// A step of zero stalls both ramps; software must program a non-zero step.
	wire [`APG_GAIN_W-1:0] step_w = {1'b0, step_ff};
	wire [`APG_GAIN_W-1:0] gain_dn = (gain_ff > step_w) ?
		gain_ff - step_w : {`APG_GAIN_W{1'b0}};
	wire [`APG_GAIN_W-1:0] gain_up = (`APG_GAIN_UNITY - gain_ff > step_w) ?
		gain_ff + step_w : `APG_GAIN_UNITY;

	always @*
	begin
		nxt_state = state_ff;
		nxt_gain  = gain_ff;
		nxt_cnt   = cnt_ff;
		case (state_ff)
		ST_NORMAL:
		begin
			// Unity is re-asserted every clock, so no stale gain can linger.
			nxt_gain = `APG_GAIN_UNITY;
			if (trig_ff)
				nxt_state = ST_ATTEN;
		end
		ST_ATTEN:
		begin
			nxt_gain = gain_dn;
			// Leaving needs the ramp finished as well as the trigger gone.
			if ((gain_ff == {`APG_GAIN_W{1'b0}}) && !trig_ff)
			begin
				nxt_state = ST_WAIT;
				nxt_cnt   = wait_ff;
			end
		end
		ST_WAIT:
		begin
			// Loaded on entry, so a wait of W holds zero gain for W+1 cycles.
			nxt_gain = {`APG_GAIN_W{1'b0}};
			if (cnt_ff != 16'h0000)
				nxt_cnt = cnt_ff - 16'h0001;
			else if (!trig_ff)
				nxt_state = ST_GAIN;
			else
				nxt_state = ST_WAIT;
		end
		ST_GAIN:
		begin
			nxt_gain = gain_up;
			// A new trigger during the up ramp goes straight back down rather
			// than finishing the ramp into a level that is already too hot.
			if (trig_ff)
				nxt_state = ST_ATTEN;
			else if (gain_ff == `APG_GAIN_UNITY)
				nxt_state = ST_NORMAL;
		end
		// All four codes are used; this branch only parks the machine safely.
		default:
		begin
			nxt_state = ST_NORMAL;
			nxt_gain  = `APG_GAIN_UNITY;
		end
		endcase
	end

	always @(posedge i_core_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			state_ff  <= ST_NORMAL;
			gain_ff   <= `APG_GAIN_UNITY;
			cnt_ff    <= 16'h0000;
			active_ff <= 1'b0;
			o_trig    <= 1'b0;
		end
		else if (!en_ff)
		begin
			// Disabled: the path is transparent and the machine is parked, so
			// enabling always starts from a known state.
			state_ff  <= ST_NORMAL;
			gain_ff   <= `APG_GAIN_UNITY;
			cnt_ff    <= 16'h0000;
			o_trig    <= 1'b0;
			if (wr_ctl & i_avs_writedata[`APG_CTRL_EN] == 1'b0)
				active_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			gain_ff  <= nxt_gain;
			cnt_ff   <= nxt_cnt;
			// The pin is one clock behind the status trigger bit.
			o_trig   <= trig_ff;
			// Sticky; a fresh trigger wins over a clear by writing the
			// status register.
			if (trig_ff)
				active_ff <= 1'b1;
			else if (wr_sts & i_avs_writedata[`APG_ST_ACTIVE])
				active_ff <= 1'b0;
		end
	end

	// ==========================================================
	// Gain applied to all sixteen samples
	// Unity is a straight copy; at unity the truncating product gives the same
	// value for every sample, so the normal state is bit exact either way.
	// Other gains truncate toward minus infinity.
	generate
		for (gi = 0; gi < `APG_NSAMP; gi = gi + 1)
		begin : g_scale
			wire signed [15:0] smp = i_data[gi*16+15:gi*16];
			wire signed [27:0] prod = smp * $signed({1'b0, gain_ff});
			always @(posedge i_core_clk or negedge i_nrst)
			begin
				if (!i_nrst)
					o_data[gi*16+15:gi*16] <= 16'h0000;
				else if (!en_ff || gain_ff == `APG_GAIN_UNITY)
					o_data[gi*16+15:gi*16] <= i_data[gi*16+15:gi*16];
				else
					o_data[gi*16+15:gi*16] <= prod[25:10];
			end
		end
	endgenerate

endmodule // apg_guard

`default_nettype wire

// ---- sim/apg_guard_monitor.sv ----
/*
 Port checker of the power guard: bus handshake, status fields, reset.
 Assumes it is bound to apg_guard and finds apg_defs.vh on the path.
*/
`include "apg_defs.vh"
`default_nettype none
// ==========================================================
// Checker
module apg_guard_monitor (
	input wire logic         i_core_clk,        // Core clock
	input wire logic         i_nrst,            // Reset, active low
	input wire logic         o_trig,            // Trigger
	input wire logic [4:0]   i_avs_address,     // Address
	input wire logic         i_avs_read,        // Read
	input wire logic [31:0]  o_avs_readdata,    // Read data
	input wire logic         o_avs_waitrequest  // Stall
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_nrst);
	wire rd_ok = i_avs_read && !o_avs_waitrequest;
	wire st_rd = rd_ok && i_avs_address == `APG_OFS_STATUS;
	wire [10:0] gain = o_avs_readdata[26:16];
	a_reset_trig_low: assert property ($rose(i_nrst) |-> !o_trig)
		else $error("trigger high after reset");
	a_read_answered: assert property ($rose(i_avs_read) |=> !o_avs_waitrequest)
		else $error("read not answered");
	a_wait_one_cycle: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
		else $error("waitrequest low too long");
	a_normal_unity: assert property (st_rd && o_avs_readdata[3:2] == 2'h0 |-> gain == `APG_GAIN_UNITY)
		else $error("normal state without unity gain");
	a_wait_gain_zero: assert property (st_rd && o_avs_readdata[3:2] == 2'h2 |-> gain == 11'h000)
		else $error("gain not zero in wait");
	a_gain_capped: assert property (st_rd |-> gain <= `APG_GAIN_UNITY && o_avs_readdata[31:27] == 5'h00)
		else $error("gain above unity");
	a_accum_width: assert property (rd_ok && i_avs_address == `APG_OFS_ACCUM |-> o_avs_readdata[31:16] == 16'h0000)
		else $error("moving sum too wide");
	a_hole_zero: assert property (rd_ok && i_avs_address > `APG_OFS_ACCUM |-> o_avs_readdata == 32'h0)
		else $error("unmapped read not zero");
endmodule // apg_guard_monitor

bind apg_guard apg_guard_monitor u_mon (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .o_trig(o_trig),
	.i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .o_avs_readdata(o_avs_readdata),
	.o_avs_waitrequest(o_avs_waitrequest));
`default_nettype wire

// ---- sim/apg_src.sv ----
/*
 Upstream sample path model: sixteen samples a clock and a sync pulse.
 Assumes the bench sets the detector byte and requests pulses.
*/
`default_nettype none
// ==========================================================
// Sample source
module apg_src (
	input  wire logic         i_core_clk, // Core clock
	input  wire logic [7:0]   i_amp,      // Upper byte of samples 0..7
	input  wire logic         i_pulse,    // Sync request
	output var  logic [255:0] o_data,     // Sixteen samples
	output var  logic         o_sync      // Sync pulse
);
	timeunit 1ns;
	timeprecision 1ps;
	integer seed = 32'h2f61f930;
	integer k;
	initial o_data = 256'h0;
	initial o_sync = 1'b0;
	// Bits the detector must ignore change every clock, so a wrong slice shows.
	always @(posedge i_core_clk)
	begin
		for (k = 0; k < 16; k = k + 1)
			o_data[16*k +: 16] <= {(k < 8) ? i_amp : 8'($random(seed)), 8'($random(seed))};
		o_sync <= i_pulse;
	end
endmodule // apg_src
`default_nettype wire

// ---- sim/apg_guard_tb_top.sv ----
/*
 Self-checking bench of the power guard.
 Assumes apg_guard, apg_src and the checker are compiled before it.
*/
`include "apg_defs.vh"
`default_nettype none
// ==========================================================
// Bench
module apg_guard_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, nrst = 1'b0, pulse = 1'b0, sync, rd = 1'b0, wr = 1'b0, wrq, trig;
	logic [7:0] amp = 8'h00;
	logic [4:0] adr = 5'h00;
	logic [31:0] wd = 32'h0, rdata, v, full;
	logic [255:0] din, od, prev;
	integer mismatches = 0, n_compared = 0, seed = 32'h2f61f930, i, a, n;
	logic [31:0] rst_v [5] = '{32'h0, 32'h1, 32'h0, 32'hffff, 32'h0};
	logic [4:0] rst_a [5] = '{5'h00, 5'h04, 5'h08, 5'h0c, 5'h18};
	apg_src src (.i_core_clk(clk), .i_amp(amp), .i_pulse(pulse), .o_data(din), .o_sync(sync));
	apg_guard dut (.i_core_clk(clk), .i_nrst(nrst), .i_data(din), .i_sync(sync), .o_data(od),
		.o_trig(trig), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
		.i_avs_writedata(wd), .o_avs_readdata(rdata), .o_avs_waitrequest(wrq));
	initial forever #2.5 clk = ~clk;
	always @(posedge clk) prev <= din;
	function automatic logic [31:0] acc_exp(input integer len, input logic [7:0] s);
		acc_exp = (4 << len) * 8 * (s[7] ? 9'h100 - s : s);
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
	begin
		n_compared++;
		if (s !== e)
		begin
			mismatches++;
			$display("BAD %s exp %h got %h", nm, e, s);
		end
	end
	endtask
	task automatic bus(input logic w, input logic [4:0] ad, input logic [31:0] d);
		integer t;
	begin
		@(posedge clk);
		rd <= !w;
		wr <= w;
		adr <= ad;
		wd <= d;
		t = 0;
		do
		begin
			@(posedge clk);
			t++;
		end
		while (wrq !== 1'b0 && t < 50);
		v = rdata;
		if (t >= 50)
			chk("bus", 0, 1);
		rd <= 1'b0;
		wr <= 1'b0;
	end
	endtask
	task automatic poll(input logic [1:0] st);
	begin
		n = 0;
		do
		begin
			bus(0, `APG_OFS_STATUS, 0);
			n++;
		end
		while (v[3:2] !== st && n < 500);
		chk("state", st, v[3:2]);
	end
	endtask
	task summarize;
	begin
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	end
	endtask
	initial
	begin
		#200000;
		mismatches++;
		summarize;
	end
	initial
	begin
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		for (i = 0; i < 5; i++)
		begin
			bus(0, rst_a[i], 0);
			chk("reset value", rst_v[i], v);
		end
		amp <= 8'h7f;
		repeat (4) @(posedge clk);
		#1 chk("bypass", 1, od === prev);
		for (i = 0; i < 3; i++)
		begin
			a = $random(seed) % 100;
			amp <= (i == 0) ? 8'h80 : a[7:0];
			bus(1, `APG_OFS_CTRL, {i[1:0], 4'h1});
			bus(1, `APG_OFS_CTRL, {2'h3, 4'h1});
			bus(0, `APG_OFS_CTRL, 0);
			chk("length", i, v[5:4]);
			repeat (40) @(posedge clk);
			full = acc_exp(i, amp);
			bus(0, `APG_OFS_ACCUM, 0);
			chk("accum", full, v);
			@(posedge clk);
			#1 chk("unity", 1, od === prev);
		end
		pulse <= 1'b1;
		@(posedge clk) pulse <= 1'b0;
		bus(0, `APG_OFS_ACCUM, 0);
		chk("ext sync", 1, v < full);
		bus(1, `APG_OFS_CTRL, 32'h23);
		repeat (40) @(posedge clk) pulse <= 1'b1;
		pulse <= 1'b0;
		bus(0, `APG_OFS_ACCUM, 0);
		chk("ext ignored", full, v);
		bus(1, `APG_OFS_CTRL, 32'h27);
		bus(0, `APG_OFS_ACCUM, 0);
		chk("sw sync", 1, v < full);
		bus(1, `APG_OFS_CTRL, 32'h03);
		bus(1, `APG_OFS_STEP, 32'h100);
		bus(1, `APG_OFS_WAIT, 32'd60);
		bus(1, `APG_OFS_THRESH, 32'h10);
		amp <= 8'h40;
		poll(2'h1);
		chk("down step", 0, v[23:16]);
		#1 chk("trig", 1, trig);
		amp <= 8'h00;
		poll(2'h2);
		#1 chk("muted", 1, od === 256'h0);
		chk("trig low", 0, trig);
		bus(0, `APG_OFS_STATUS, 0);
		chk("counting", 2'h2, v[3:2]);
		amp <= 8'h40;
		repeat (90) @(posedge clk);
		bus(0, `APG_OFS_STATUS, 0);
		chk("held", 2'h2, v[3:2]);
		#1 chk("trig held", 1, trig);
		amp <= 8'h00;
		poll(2'h3);
		chk("up step", 0, v[23:16]);
		poll(2'h0);
		chk("gain", `APG_GAIN_UNITY, v[26:16]);
		chk("active", 1, v[0]);
		bus(1, `APG_OFS_STATUS, 32'h1);
		bus(0, `APG_OFS_STATUS, 0);
		chk("cleared", 0, v[0]);
		summarize;
	end
endmodule // apg_guard_tb_top
`default_nettype wire
